// ---- design/sio_pkg.sv ----
package sio_pkg;
	localparam logic [15:0] SIO_ADDR = 16'h0201;
	localparam int SIO_WD_EN_BIT = 0;
	localparam int SIO_WD_REF_BIT = 1;
	localparam int SIO_VPP_BIT = 2;
	localparam int SIO_DIR485_BIT = 3;
	localparam int SIO_PWRFAIL_BIT = 3;
	localparam int SIO_LPTDIR_BIT = 4;
	localparam int SIO_SWBANK_BIT = 5;
	localparam logic [7:0] SIO_RESET_VAL = 8'h00;
	localparam logic [7:0] SIO_WMASK = 8'h1F;
	localparam longint SIO_CLK_HZ = 200000000;
	localparam longint SIO_WD_TIMEOUT_MS = 1600;
	localparam longint SIO_WD_CYCLES = SIO_WD_TIMEOUT_MS * SIO_CLK_HZ / 1000;
	localparam int SIO_RST_PULSE_CYC = 16;
	localparam int SIO_SYNC_W = 2;
	localparam int SIO_SYNC_PF_IDX = 0;
	localparam int SIO_SYNC_SW_IDX = 1;
endpackage

// ---- design/sio_wdog.sv ----
`timescale 1ns/1ps
module sio_wdog
	import sio_pkg::*;
#(
	parameter int unsigned TIMEOUT = 32'(SIO_WD_CYCLES),
	parameter int unsigned PULSE = SIO_RST_PULSE_CYC
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic enable,
	input wire logic refresh,
	output logic bite
);
	typedef enum logic [1:0] {SIO_IDLE, SIO_RUN, SIO_BITE} sio_wd_t;
	sio_wd_t st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		unique case (st_r)
			SIO_IDLE: begin
				cnt_nxt = '0;
				if (enable) begin
					st_nxt = SIO_RUN;
				end
			end
			SIO_RUN: begin
				if (!enable) begin
					st_nxt = SIO_IDLE;
				end else if (refresh) begin
					cnt_nxt = '0;
				end else if (cnt_r >= TIMEOUT - 1) begin
					st_nxt = SIO_BITE;
					cnt_nxt = '0;
				end else begin
					cnt_nxt = cnt_r + 32'd1;
				end
			end
			SIO_BITE: begin
				if (cnt_r >= PULSE - 1) begin
					st_nxt = SIO_IDLE;
					cnt_nxt = '0;
				end else begin
					cnt_nxt = cnt_r + 32'd1;
				end
			end
			default: begin
				st_nxt = SIO_IDLE;
				cnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= SIO_IDLE;
			cnt_r <= '0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign bite = (st_r == SIO_BITE);
endmodule

// ---- design/sio_supervisor.sv ----
`timescale 1ns/1ps
// Function
// - register answers at io address 201h
// - bit0 watchdog enable, read/write
// - bit1 refresh, toggled 1-0-1 to refresh
// - bit2 flash vpp select, 1=12v
// - bit3 write rs485 enable, read powerfail
// - bit4 write-only printer data direction
// - bit5 reads first switch bank selected
// - all stored bits clear after reset; bits 3 and 5 read their pins
// - refresh within 1.6s else reset pulse
// - powerfail bit zero means low power
module sio_supervisor
	import sio_pkg::*;
#(
	parameter int unsigned WD_TIMEOUT = 32'(SIO_WD_CYCLES)
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic io_sel,
	input wire logic power_fail_output_n,
	input wire logic first_switch_bank,
	output logic wdog_reset,
	output logic vpp_12v,
	output logic rs485_dir_en,
	output logic lpt_data_input
);
	typedef enum logic [1:0] {
		SIO_REF_SEEK_HIGH,
		SIO_REF_SEEK_LOW,
		SIO_REF_SEEK_RISE
	} sio_ref_t;

	logic [4:0] reg_r, reg_nxt;
	logic [SIO_SYNC_W-1:0] s1_r, s1_nxt;
	logic [SIO_SYNC_W-1:0] s2_r, s2_nxt;
	sio_ref_t ref_st_r, ref_st_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic bite_r, bite_nxt;
	logic wr_hit, rd_hit, ref_bit, refresh, bite_raw;

	// one decode for both strobes, so a read and a write can never
	// disagree about which address is ours
	function automatic logic sio_addr_match(input logic [15:0] a);
		return a == SIO_ADDR;
	endfunction

	// bits 6 and 7 have no storage; writing them is harmless
	function automatic logic [4:0] sio_store_bits(input logic [7:0] d);
		logic [7:0] kept;
		kept = d & SIO_WMASK;
		return kept[4:0];
	endfunction

	// bit3 reads the detector pin, not the stored direction enable,
	// and bit4 never reads back: software must keep its own copy
	function automatic logic [7:0] sio_read_view(
		input logic [4:0] stored,
		input logic pf_n,
		input logic sw_first
	);
		logic [7:0] view;
		view = 8'h00;
		view[SIO_WD_EN_BIT] = stored[SIO_WD_EN_BIT];
		view[SIO_WD_REF_BIT] = stored[SIO_WD_REF_BIT];
		view[SIO_VPP_BIT] = stored[SIO_VPP_BIT];
		view[SIO_PWRFAIL_BIT] = pf_n;
		view[SIO_SWBANK_BIT] = sw_first;
		return view;
	endfunction

	assign wr_hit = io_wr & sio_addr_match(io_addr);
	assign rd_hit = io_rd & sio_addr_match(io_addr);
	assign io_sel = wr_hit | rd_hit;
	assign ref_bit = io_wdata[SIO_WD_REF_BIT];

	// pins are asynchronous: only the second flop is read by logic
	always_comb begin
		s1_nxt = '0;
		s1_nxt[SIO_SYNC_PF_IDX] = power_fail_output_n;
		s1_nxt[SIO_SYNC_SW_IDX] = first_switch_bank;
		s2_nxt = s1_r;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	always_comb begin
		reg_nxt = reg_r;
		if (wr_hit) begin
			reg_nxt = sio_store_bits(io_wdata);
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reg_r <= SIO_RESET_VAL[4:0];
		end else begin
			reg_r <= reg_nxt;
		end
	end

	// the closing 1 also opens the next 1-0-1, so sequences may share
	// it; a repeated level changes nothing, so a stuck bit never refreshes
	always_comb begin
		ref_st_nxt = ref_st_r;
		refresh = 1'b0;
		if (wr_hit) begin
			unique case (ref_st_r)
				SIO_REF_SEEK_HIGH: begin
					if (ref_bit) begin
						ref_st_nxt = SIO_REF_SEEK_LOW;
					end
				end
				SIO_REF_SEEK_LOW: begin
					if (!ref_bit) begin
						ref_st_nxt = SIO_REF_SEEK_RISE;
					end
				end
				SIO_REF_SEEK_RISE: begin
					if (ref_bit) begin
						refresh = 1'b1;
						ref_st_nxt = SIO_REF_SEEK_LOW;
					end
				end
				default: begin
					ref_st_nxt = SIO_REF_SEEK_HIGH;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ref_st_r <= SIO_REF_SEEK_HIGH;
		end else begin
			ref_st_r <= ref_st_nxt;
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (rd_hit) begin
			rdata_nxt = sio_read_view(reg_r,
				s2_r[SIO_SYNC_PF_IDX], s2_r[SIO_SYNC_SW_IDX]);
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= SIO_RESET_VAL;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// the reset pulse leaves from a flop so decode glitches stay inside
	always_comb begin
		bite_nxt = bite_raw;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bite_r <= 1'b0;
		end else begin
			bite_r <= bite_nxt;
		end
	end

	assign io_rdata = rdata_r;
	assign vpp_12v = reg_r[SIO_VPP_BIT];
	assign rs485_dir_en = reg_r[SIO_DIR485_BIT];
	assign lpt_data_input = reg_r[SIO_LPTDIR_BIT];
	assign wdog_reset = bite_r;

	sio_wdog #(
		.TIMEOUT(WD_TIMEOUT),
		.PULSE(SIO_RST_PULSE_CYC)
	) u_wdog (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.enable(reg_r[SIO_WD_EN_BIT]),
		.refresh(refresh),
		.bite(bite_raw)
	);
endmodule

// ---- testbench/sio_asserts.sv ----
`timescale 1ns/1ps
module sio_asserts
	import sio_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic io_sel,
	input wire logic wdog_reset,
	input wire logic vpp_12v,
	input wire logic rs485_dir_en,
	input wire logic lpt_data_input
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire w = io_wr && io_addr == SIO_ADDR;
	wire r = io_rd && io_addr == SIO_ADDR;
	sequence s_bite; ##15 wdog_reset ##1 !wdog_reset; endsequence
	a_sel_decode: assert property (io_sel == (w || r))
		else $error("sel");
	a_vpp_write: assert property (w |=> vpp_12v == $past(io_wdata[2]))
		else $error("vpp");
	a_dir_write: assert property (w |=>
		{lpt_data_input, rs485_dir_en} == $past(io_wdata[4:3]))
		else $error("dir");
	a_ctl_hold: assert property (!w |=> $stable(vpp_12v))
		else $error("hold");
	a_rd_unused: assert property (r |=> io_rdata[7:6] == 2'h0)
		else $error("unused");
	a_rd_vpp: assert property (r |=> io_rdata[2] == $past(vpp_12v))
		else $error("rvpp");
	a_rd_idle: assert property (!r |=> io_rdata == 8'h00)
		else $error("idle");
	a_wd_pulse: assert property ($rose(wdog_reset) |-> s_bite)
		else $error("bite");
endmodule
bind sio_supervisor sio_asserts u_chk (.*);

// ---- testbench/sio_host.sv ----
`timescale 1ns/1ps
module sio_host
	import sio_pkg::*;
(
	input wire logic ref_clk,
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata
);
	logic [7:0] shadow = 8'h00;
	initial {io_addr, io_wr, io_rd, io_wdata} = '0;
	// released bus shows inverted values so stale data cannot pass
	task automatic cyc(logic [15:0] a, logic w, logic [7:0] d,
		output logic [7:0] q);
		@(negedge ref_clk);
		{io_addr, io_wr, io_rd, io_wdata} = {a, w, !w, d};
		@(negedge ref_clk);
		q = io_rdata;
		{io_addr, io_wr, io_rd, io_wdata} = {~a, 2'b00, ~d};
	endtask
	task automatic put(logic [7:0] d);
		logic [7:0] q;
		shadow = d;
		cyc(SIO_ADDR, 1'b1, d, q);
	endtask
	task automatic kick();
		put(shadow | 8'h02);
		put(shadow & 8'hFD);
		put(shadow | 8'h02);
	endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench
	import sio_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic power_fail_output_n = 1'b0;
	logic first_switch_bank = 1'b0;
	logic [15:0] io_addr;
	logic io_wr, io_rd, io_sel, wdog_reset;
	logic vpp_12v, rs485_dir_en, lpt_data_input;
	logic [7:0] io_wdata, io_rdata, q;
	int n_errors = 0;
	int checked = 0;
	int bites = 0;
	int sels = 0;
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) bites <= bites + int'(wdog_reset);
	always @(posedge ref_clk) sels <= sels + int'(io_sel);
	sio_supervisor #(.WD_TIMEOUT(200)) u_dut (.*);
	sio_host u_host (.*);
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t %h %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (n_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic rd(logic [7:0] exp);
		u_host.cyc(SIO_ADDR, 1'b0, 8'h00, q);
		chk(q, exp);
	endtask
	task automatic t_bits();
		int s0;
		rd(8'h00);
		u_host.put(8'hDE);
		chk(8'({vpp_12v, rs485_dir_en, lpt_data_input}), 8'h07);
		rd(8'h06);
		{power_fail_output_n, first_switch_bank} = 2'b11;
		repeat (4) @(negedge ref_clk);
		s0 = sels;
		rd(8'h2E);
		chk(8'(sels - s0), 8'h01);
		s0 = sels;
		u_host.cyc(16'h0200, 1'b1, 8'h00, q);
		chk(8'(sels - s0), 8'h00);
		chk(8'(lpt_data_input), 8'h01);
	endtask
	task automatic t_wdog();
		int base;
		u_host.put(8'h01);
		rd(8'h29);
		base = bites;
		repeat (3) begin
			repeat (150) @(negedge ref_clk);
			u_host.kick();
		end
		chk(8'(bites - base), 8'h00);
		repeat (300) @(negedge ref_clk);
		chk(8'(bites - base), 8'h10);
	endtask
	task automatic t_reset();
		u_host.put(8'h1F);
		chk(8'({vpp_12v, rs485_dir_en, lpt_data_input}), 8'h07);
		power_fail_output_n = 1'b0;
		rstn = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk(8'({vpp_12v, rs485_dir_en, lpt_data_input}), 8'h00);
		rstn = 1'b1;
		repeat (3) @(negedge ref_clk);
		rd(8'h20);
	endtask
	initial begin
		repeat (6) @(negedge ref_clk);
		rstn = 1'b1;
		t_bits();
		t_wdog();
		t_reset();
		complete_run();
	end
	initial begin
		#20000;
		n_errors++;
		complete_run();
	end
endmodule
